/* core/fcmp_maint_port.sv */
// Purpose: maintenance and diagnostic port of the float coprocessor
// Assumes: io strobe is one cycle, synchronous to i_clk
// Notes: sequences fetch state 0 for special-format instructions
// Notes on behaviour
// R1: leave, clear-accumulator, start-float, start-double end in fetch state 0.
// R2: false conditional jump ends in fetch state 0, no branch.
// R3: other special instructions enter process at the start of state 1.
// R4: in maintenance mode halt after every major time state.
// R5: code 6561 sets maintenance mode, normally before the launch instruction.
// R6: code 6561 while halted advances to the next time state.
// R7: clearing the interrupt request flag clears maintenance mode.
// R8: maintenance read data is ORed into the host accumulator.
// R9: code 6562 returns time state and major state flags.
// R10: state word bits 00-03 hold time counter, bit 00 its msb.
// R11: bits 04-09: deposit, fetch, execute, exit, initiate, process.
// R12: bit 10 fraction-shift substate, bit 11 no-shift substate.
// R13: code 6563 ORs the result high word into the accumulator.
// R14: code 6564 ORs the result low word into the accumulator.
// R15: code 6565 ORs low 12 bits of argument table pointer.
// R16: code 6566 ORs the multiplier-quotient low word.
// R17: code 6567 loads the shift counter from six accumulator bits.
// R18: host clears its accumulator before reading the pointer.
// R19: maintenance reads change no internal register or state.
`timescale 1ns/1ps
module fcmp_maint_port
	import fcmp_pkg::*;
(
	input  wire logic               i_clk,
	input  wire logic               i_nrst,
	input  wire logic               i_io_strobe,
	input  wire logic [11:0]        i_io_code,
	input  wire logic [WORD_W-1:0]  i_host_accumulator,
	input  wire logic               i_irq_clear,
	input  wire logic               i_instr_valid,
	input  wire fcmp_op_t           i_instr_op,
	input  wire logic               i_jump_cond,
	input  wire logic               i_frac_shift,
	input  wire logic               i_no_shift,
	input  wire logic [WORD_W-1:0]  i_result_high_word,
	input  wire logic [WORD_W-1:0]  i_result_low_word,
	input  wire logic [PTR_W-1:0]   i_argument_table_pointer,
	input  wire logic [WORD_W-1:0]  i_multiplier_quotient_low_word,
	output logic                    o_or_valid,
	output logic [WORD_W-1:0]       o_or_data,
	output logic [SHIFT_W-1:0]      o_shift_count,
	output logic [TS_W-1:0]         o_time_state,
	output fcmp_major_t             o_major,
	output logic                    o_maint,
	output logic                    o_halted,
	output logic                    o_instr_done,
	output logic                    o_branch
);
	logic                io_step;
	logic                io_load_shift;
	logic                read_hit;
	logic [WORD_W-1:0]   read_data;
	logic [WORD_W-1:0]   state_word;
	logic                maint;
	logic                halted;
	logic                advance;
	logic                state_end;
	logic                run;
	logic                fetch0_finish;
	logic                to_process;

	assign io_step = i_io_strobe && (i_io_code == IO_MAINT_STEP);
	assign io_load_shift = i_io_strobe && (i_io_code == IO_LOAD_SHIFT);

	// big-endian word: host bit 00 is vector bit 11
	always_comb begin
		state_word = '0;
		for (int i = 0; i < TS_W; i++)
			state_word[SW_TS_LSB + i] = o_time_state[i]; // R10
		state_word[SW_DEPOSIT] = (o_major == FCMP_MS_DEPOSIT); // R11
		state_word[SW_FETCH] = (o_major == FCMP_MS_FETCH); // R11
		state_word[SW_EXECUTE] = (o_major == FCMP_MS_EXECUTE); // R11
		state_word[SW_EXIT] = (o_major == FCMP_MS_EXIT); // R11
		state_word[SW_INITIATE] = (o_major == FCMP_MS_INITIATE); // R11
		state_word[SW_PROCESS] = (o_major == FCMP_MS_PROCESS); // R11
		state_word[SW_FRAC_SHIFT] = i_frac_shift; // R12
		state_word[SW_NO_SHIFT] = i_no_shift; // R12
	end

	fcmp_read_mux u_mux (
		.i_code       (i_io_code),
		.i_state_word (state_word),
		.i_rhi        (i_result_high_word),
		.i_rlo        (i_result_low_word),
		.i_ptr        (i_argument_table_pointer),
		.i_mqlo       (i_multiplier_quotient_low_word),
		.o_hit        (read_hit),
		.o_data       (read_data)
	);

	fcmp_step_ctl u_step (
		.i_clk       (i_clk),
		.i_nrst      (i_nrst),
		.i_step_io   (io_step),
		.i_irq_clear (i_irq_clear),
		.i_state_end (state_end),
		.o_maint     (maint),
		.o_halted    (halted),
		.o_advance   (advance)
	);

	// the host ors this into its accumulator; we never return a load
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_or_valid <= 1'b0;
			o_or_data <= '0;
		end else begin
			o_or_valid <= i_io_strobe && read_hit; // R8
			o_or_data <= (i_io_strobe && read_hit) ? read_data : '0; // R8 R19
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			o_shift_count <= '0;
		else if (io_load_shift)
			o_shift_count <= i_host_accumulator[SHIFT_W-1:0]; // R17
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_maint <= 1'b0;
			o_halted <= 1'b0;
		end else begin
			o_maint <= maint;
			o_halted <= halted;
		end
	end

	// a halted machine holds until a step or an irq clear; one step is one time state
	assign run = !halted && !advance || advance;
	assign state_end = (o_major != FCMP_MS_IDLE) && run && !halted; // R4

	assign fetch0_finish = (i_instr_op == FCMP_OP_LEAVE) || (i_instr_op == FCMP_OP_CLEAR_FAC)
		|| (i_instr_op == FCMP_OP_START_F) || (i_instr_op == FCMP_OP_START_D)
		|| ((i_instr_op == FCMP_OP_COND_JUMP) && !i_jump_cond);
	assign to_process = !fetch0_finish;

	// only the fetch/process path of special instructions is sequenced here
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_major <= FCMP_MS_IDLE;
			o_time_state <= TS_ZERO;
			o_instr_done <= 1'b0;
			o_branch <= 1'b0;
		end else begin
			o_instr_done <= 1'b0;
			o_branch <= 1'b0;
			if (i_irq_clear) begin
				o_major <= FCMP_MS_IDLE;
				o_time_state <= TS_ZERO;
			end else begin
				case (o_major)
					FCMP_MS_IDLE: begin
						if (i_instr_valid && !halted) begin
							o_major <= FCMP_MS_FETCH;
							o_time_state <= TS_ZERO;
						end
					end
					FCMP_MS_FETCH: begin
						if (state_end) begin
							if (fetch0_finish) begin
								o_major <= FCMP_MS_IDLE; // R1 R2
								o_instr_done <= 1'b1; // R1 R2
							end else if (to_process) begin
								o_major <= FCMP_MS_PROCESS; // R3
								o_time_state <= TS_ONE; // R3
								o_branch <= (i_instr_op == FCMP_OP_COND_JUMP); // R3
							end
						end
					end
					FCMP_MS_PROCESS: begin
						if (state_end) begin
							if (o_time_state == TS_LAST) begin
								o_major <= FCMP_MS_IDLE;
								o_time_state <= TS_ZERO;
								o_instr_done <= 1'b1;
							end else begin
								o_time_state <= o_time_state + TS_ONE;
							end
						end
					end
					default: begin
						o_major <= FCMP_MS_IDLE;
						o_time_state <= TS_ZERO;
					end
				endcase
			end
		end
	end
endmodule

/* core/fcmp_pkg.sv */
// Purpose: shared constants for the coprocessor maintenance port
// Assumes: 12-bit host word, bit 00 is the most significant bit
// Notes: programmed-io codes are octal device/function codes
package fcmp_pkg;
	localparam int WORD_W = 12;
	localparam int TS_W = 4;
	localparam int SHIFT_W = 6;
	localparam int PTR_W = 15;
	// programmed-io codes (octal 6561..6567)
	localparam logic [11:0] IO_MAINT_STEP = 12'hd71;
	localparam logic [11:0] IO_READ_STATE = 12'hd72;
	localparam logic [11:0] IO_READ_RHI = 12'hd73;
	localparam logic [11:0] IO_READ_RLO = 12'hd74;
	localparam logic [11:0] IO_READ_PTR = 12'hd75;
	localparam logic [11:0] IO_READ_MQLO = 12'hd76;
	localparam logic [11:0] IO_LOAD_SHIFT = 12'hd77;
	// state word field positions, numbered from lsb of the port vector
	localparam int SW_TS_LSB = 8;
	localparam int SW_DEPOSIT = 7;
	localparam int SW_FETCH = 6;
	localparam int SW_EXECUTE = 5;
	localparam int SW_EXIT = 4;
	localparam int SW_INITIATE = 3;
	localparam int SW_PROCESS = 2;
	localparam int SW_FRAC_SHIFT = 1;
	localparam int SW_NO_SHIFT = 0;
	// time state values
	localparam logic [3:0] TS_ZERO = 4'h0;
	localparam logic [3:0] TS_ONE = 4'h1;
	localparam logic [3:0] TS_LAST = 4'h3;
	// special-format opcode classes seen in fetch state 0
	typedef enum logic [2:0] {
		FCMP_OP_OTHER,
		FCMP_OP_LEAVE,
		FCMP_OP_CLEAR_FAC,
		FCMP_OP_START_F,
		FCMP_OP_START_D,
		FCMP_OP_COND_JUMP
	} fcmp_op_t;
	typedef enum logic [2:0] {
		FCMP_MS_IDLE,
		FCMP_MS_FETCH,
		FCMP_MS_PROCESS,
		FCMP_MS_EXECUTE,
		FCMP_MS_DEPOSIT,
		FCMP_MS_EXIT,
		FCMP_MS_INITIATE
	} fcmp_major_t;
endpackage

/* core/fcmp_read_mux.sv */
// Purpose: selects maintenance read data for the host accumulator
// Assumes: strobe gating done by the caller; read codes decoded here
// Notes: pure selection, never writes the sources
`timescale 1ns/1ps
module fcmp_read_mux
	import fcmp_pkg::*;
(
	input  wire logic [11:0]       i_code,
	input  wire logic [WORD_W-1:0] i_state_word,
	input  wire logic [WORD_W-1:0] i_rhi,
	input  wire logic [WORD_W-1:0] i_rlo,
	input  wire logic [PTR_W-1:0]  i_ptr,
	input  wire logic [WORD_W-1:0] i_mqlo,
	output logic                   o_hit,
	output logic [WORD_W-1:0]      o_data
);
	always_comb begin
		o_hit = 1'b1;
		case (i_code)
			IO_READ_STATE: o_data = i_state_word; // R9
			IO_READ_RHI:   o_data = i_rhi; // R13
			IO_READ_RLO:   o_data = i_rlo; // R14
			IO_READ_PTR:   o_data = i_ptr[WORD_W-1:0]; // R15
			IO_READ_MQLO:  o_data = i_mqlo; // R16
			default: begin
				o_hit = 1'b0;
				o_data = '0;
			end
		endcase
	end
endmodule

/* core/fcmp_step_ctl.sv */
// Purpose: maintenance-mode flag and single-step gate
// Assumes: i_state_end pulses at the end of each major time state
// Notes: step request wins over flag clear in the same cycle
`timescale 1ns/1ps
module fcmp_step_ctl
	import fcmp_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_step_io,
	input  wire logic i_irq_clear,
	input  wire logic i_state_end,
	output logic      o_maint,
	output logic      o_halted,
	output logic      o_advance
);
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			o_maint <= 1'b0;
		else if (i_step_io)
			o_maint <= 1'b1; // R5
		else if (i_irq_clear)
			o_maint <= 1'b0; // R7
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			o_halted <= 1'b0;
		else if (o_halted && (i_step_io || i_irq_clear))
			o_halted <= 1'b0; // R6
		else if (o_maint && i_state_end && !i_irq_clear)
			o_halted <= 1'b1; // R4
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			o_advance <= 1'b0;
		else
			o_advance <= o_halted && i_step_io; // R6
	end
endmodule

/* test/fcmp_host_model.sv */
// Purpose: host cpu issuing programmed-io codes
// Assumes: one strobe cycle per io instruction
// Notes: read data is ORed into the accumulator
`timescale 1ns/1ps
module fcmp_host_model
	import fcmp_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_or_valid,
	input  wire logic [WORD_W-1:0] i_or_data,
	output logic                   o_io_strobe,
	output logic [11:0]            o_io_code,
	output logic [WORD_W-1:0]      o_host_accumulator
);
	initial begin
		o_io_strobe = 1'b0;
		o_io_code = 12'h000;
		o_host_accumulator = 12'h000;
	end
	always @(posedge i_clk) begin
		if (i_or_valid === 1'b1)
			o_host_accumulator <= o_host_accumulator | i_or_data;
	end
	// ac of zero before a pointer read gives pure pointer bits
	task programmed_io_code(input logic [11:0] code, input logic [11:0] ac);
		@(negedge i_clk);
		o_host_accumulator = ac;
		o_io_code = code;
		o_io_strobe = 1'b1;
		@(negedge i_clk);
		o_io_strobe = 1'b0;
		o_io_code = ~code;
	endtask
endmodule

/* test/fcmp_maint_port_sva.sv */
// Purpose: port-level checks of the maintenance port
// Assumes: reads answer one cycle after the strobe edge
// Notes: sees top ports only
`timescale 1ns/1ps
module fcmp_maint_port_sva
	import fcmp_pkg::*;
(
	input wire logic               i_clk,
	input wire logic               i_nrst,
	input wire logic               i_io_strobe,
	input wire logic [11:0]        i_io_code,
	input wire logic [WORD_W-1:0]  i_host_accumulator,
	input wire logic               i_irq_clear,
	input wire logic [WORD_W-1:0]  i_result_high_word,
	input wire logic [PTR_W-1:0]   i_argument_table_pointer,
	input wire logic               o_or_valid,
	input wire logic [WORD_W-1:0]  o_or_data,
	input wire logic [SHIFT_W-1:0] o_shift_count,
	input wire logic [TS_W-1:0]    o_time_state,
	input wire fcmp_major_t        o_major,
	input wire logic               o_maint,
	input wire logic               o_halted,
	input wire logic               o_branch
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	wire logic stp = i_io_strobe && i_io_code == IO_MAINT_STEP;
	wire logic rd = i_io_strobe && i_io_code inside {[IO_READ_STATE:IO_READ_MQLO]};
	sequence s_step;
		stp;
	endsequence
	sequence s_proc1;
		o_major == FCMP_MS_PROCESS && o_time_state == TS_ONE;
	endsequence
	rd_answer_a: assert property (rd |=> o_or_valid) else $error("read unanswered");
	no_answer_a: assert property (!rd |=> !o_or_valid && o_or_data == 12'h000) else $error("stray data");
	rd_high_a: assert property (i_io_strobe && i_io_code == IO_READ_RHI |=>
		o_or_data == $past(i_result_high_word)) else $error("bad high word");
	rd_ptr_a: assert property (i_io_strobe && i_io_code == IO_READ_PTR |=>
		o_or_data == $past(i_argument_table_pointer[11:0])) else $error("bad pointer");
	shift_load_a: assert property (i_io_strobe && i_io_code == IO_LOAD_SHIFT |=>
		o_shift_count == $past(i_host_accumulator[5:0])) else $error("bad shift load");
	read_quiet_a: assert property (rd |=> $stable(o_shift_count)) else $error("read changed count");
	// o_maint is a registered copy of the internal flag, so it shows one cycle later
	maint_set_a: assert property (s_step |=> ##1 o_maint) else $error("maint not set");
	maint_clr_a: assert property (i_irq_clear && !stp |=> ##1 !o_maint) else $error("maint kept");
	branch_ts1_a: assert property (o_branch |-> s_proc1) else $error("branch outside ts1");
	halt_hold_a: assert property (o_halted && $past(o_halted) && !stp && !$past(stp) && !i_irq_clear
		|=> $stable(o_time_state) && $stable(o_major)) else $error("moved while halted");
endmodule
bind fcmp_maint_port fcmp_maint_port_sva u_sva (.i_clk, .i_nrst, .i_io_strobe, .i_io_code,
	.i_host_accumulator, .i_irq_clear, .i_result_high_word, .i_argument_table_pointer, .o_or_valid,
	.o_or_data, .o_shift_count, .o_time_state, .o_major, .o_maint, .o_halted, .o_branch);

/* test/fcmp_maint_port_tb_top.sv */
// Purpose: self-checking bench of the maintenance port
// Assumes: inputs change at the falling edge
// Notes: expected read data queued by the driver
`timescale 1ns/1ps
module fcmp_maint_port_tb_top import fcmp_pkg::*;;
	logic i_clk = 1'b0, i_nrst = 1'b0, i_irq_clear = 1'b0, i_instr_valid = 1'b0;
	logic i_jump_cond = 1'b0, i_frac_shift = 1'b0, i_no_shift = 1'b0;
	fcmp_op_t i_instr_op = FCMP_OP_OTHER;
	logic [11:0] i_result_high_word = 0, i_result_low_word = 0, i_multiplier_quotient_low_word = 0;
	logic [14:0] i_argument_table_pointer = 0;
	logic i_io_strobe, o_or_valid, o_maint, o_halted, o_instr_done, o_branch;
	logic [11:0] i_io_code, i_host_accumulator, o_or_data, v;
	logic [5:0] o_shift_count;
	logic [3:0] o_time_state;
	fcmp_major_t o_major;
	fcmp_op_t fast[5] = '{FCMP_OP_LEAVE, FCMP_OP_CLEAR_FAC, FCMP_OP_START_F, FCMP_OP_START_D, FCMP_OP_COND_JUMP};
	logic [11:0] exp_q[$];
	int errors = 0, cmp_count = 0, proc = 0, seed, k;
	always #5 i_clk = ~i_clk;
	fcmp_maint_port DUT (.i_clk, .i_nrst, .i_io_strobe, .i_io_code, .i_host_accumulator, .i_irq_clear,
		.i_instr_valid, .i_instr_op, .i_jump_cond, .i_frac_shift, .i_no_shift, .i_result_high_word,
		.i_result_low_word, .i_argument_table_pointer, .i_multiplier_quotient_low_word, .o_or_valid,
		.o_or_data, .o_shift_count, .o_time_state, .o_major, .o_maint, .o_halted, .o_instr_done, .o_branch);
	fcmp_host_model u_host (.i_clk, .i_or_valid(o_or_valid), .i_or_data(o_or_data),
		.o_io_strobe(i_io_strobe), .o_io_code(i_io_code), .o_host_accumulator(i_host_accumulator));
	task test_done;
		if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [11:0] got, input logic [11:0] want);
		cmp_count++;
		if (got !== want) begin
			errors++;
			$display("ERROR %0t got %h want %h", $time, got, want);
		end
	endtask
	function automatic bit hit(input int w);
		case (w)
			0: return o_major !== FCMP_MS_IDLE;
			1: return o_instr_done === 1'b1;
			2: return o_halted === 1'b1;
			default: return o_major === FCMP_MS_PROCESS;
		endcase
	endfunction
	task wait_on(input int w);
		int n;
		n = 0;
		while (!hit(w) && n < 100) begin
			@(negedge i_clk);
			n++;
		end
		if (!hit(w)) begin
			errors++;
			$display("ERROR %0t timeout", $time);
			test_done;
		end
	endtask
	task launch(input fcmp_op_t op, input logic c);
		i_instr_op = op;
		i_jump_cond = c;
		i_instr_valid = 1'b1;
		wait_on(0);
		i_instr_valid = 1'b0;
	endtask
	always @(negedge i_clk) begin
		if (o_major === FCMP_MS_PROCESS || o_branch === 1'b1) proc++;
		if (o_or_valid === 1'b1) begin
			if (exp_q.size() == 0) chk(o_or_data, 12'h000);
			else chk(o_or_data, exp_q.pop_front());
		end
	end
	initial begin
		seed = 4;
		repeat (20) @(negedge i_clk);
		i_nrst = 1'b1;
		i_result_high_word = $random(seed);
		i_result_low_word = $random(seed);
		i_argument_table_pointer = $random(seed);
		i_multiplier_quotient_low_word = $random(seed);
		{i_frac_shift, i_no_shift} = $random(seed);
		exp_q.push_back({10'h000, i_frac_shift, i_no_shift});
		u_host.programmed_io_code(IO_READ_STATE, 12'h000);
		exp_q.push_back(i_result_high_word);
		u_host.programmed_io_code(IO_READ_RHI, 12'hfff);
		exp_q.push_back(i_result_low_word);
		u_host.programmed_io_code(IO_READ_RLO, 12'h000);
		exp_q.push_back(i_argument_table_pointer[11:0]);
		u_host.programmed_io_code(IO_READ_PTR, 12'h000);
		exp_q.push_back(i_multiplier_quotient_low_word);
		u_host.programmed_io_code(IO_READ_MQLO, 12'h000);
		repeat (2) @(negedge i_clk);
		chk(i_host_accumulator, i_multiplier_quotient_low_word);
		v = $random(seed);
		u_host.programmed_io_code(IO_LOAD_SHIFT, v);
		@(negedge i_clk);
		chk({6'h00, o_shift_count}, {6'h00, v[5:0]});
		for (k = 0; k < 5; k++) begin
			proc = 0;
			launch(fast[k], 1'b0);
			wait_on(1);
			chk(proc[11:0], 12'h000);
		end
		u_host.programmed_io_code(IO_MAINT_STEP, 12'h000);
		launch(FCMP_OP_COND_JUMP, 1'b1);
		wait_on(3);
		chk({11'h000, o_branch}, 12'h001);
		// the halt lands after fetch 0 has ended, so the machine waits in process ts1
		wait_on(2);
		chk({9'h000, o_major}, {9'h000, FCMP_MS_PROCESS});
		chk({8'h00, o_time_state}, {8'h00, TS_ONE});
		for (k = 0; k < 2; k++) begin
			exp_q.push_back({TS_ONE, 6'h01, i_frac_shift, i_no_shift});
			u_host.programmed_io_code(IO_READ_STATE, 12'h000);
		end
		repeat (3) @(negedge i_clk);
		chk({8'h00, o_time_state}, {8'h00, TS_ONE});
		u_host.programmed_io_code(IO_MAINT_STEP, 12'h000);
		// o_halted lags a cycle; let it drop before waiting for the next halt
		@(negedge i_clk);
		wait_on(2);
		chk({8'h00, o_time_state}, {8'h00, 4'h2});
		i_irq_clear = 1'b1;
		@(negedge i_clk);
		i_irq_clear = 1'b0;
		@(negedge i_clk);
		chk({11'h000, o_maint}, 12'h000);
		test_done;
	end
endmodule
